// ===== core/pic_port_irq.v
// Port direction, pull and open-drain gating, and interrupt enable/flag logic.
`timescale 1ns/100ps
`include "pic_regs.vh"

module pic_port_irq
#(
  parameter NA = 4,
  parameter NB = 8
)
(
  input  wire          i_clk,
  input  wire          i_rst,
  input  wire [7:0]    i_addr,
  input  wire          i_wr,
  input  wire          i_rd,
  input  wire [7:0]    i_wdata,
  output reg  [7:0]    o_rdata,
  input  wire [7:0]    i_accumulator_reg,
  input  wire          i_option_load,
  input  wire          i_direction_load,
  input  wire [7:0]    i_direction_addr,
  input  wire          i_return_from_interrupt,
  input  wire          i_sleeping,
  input  wire          i_timer_rollover,
  input  wire [NA-1:0] i_alt_func_a,
  input  wire [NB-1:0] i_alt_func_b,
  input  wire [NA-1:0] i_port_a_in,
  output wire [NA-1:0] o_port_a_out,
  output wire [NA-1:0] o_port_a_oe,
  output wire [NA-1:0] o_port_a_pulldown,
  input  wire [NB-1:0] i_port_b_in,
  output wire [NB-1:0] o_port_b_out,
  output wire [NB-1:0] o_port_b_oe,
  output wire [NB-1:0] o_port_b_pullup,
  output wire [NB-1:0] o_port_b_pulldown,
  output wire          o_irq_take,
  output wire [10:0]   o_irq_vector,
  output wire          o_wake,
  output wire          o_wake_branch,
  output wire          o_timer_source_select,
  output wire          o_timer_source_edge,
  output wire          o_prescaler_assign,
  output wire [2:0]    o_prescaler_rate,
  output wire          o_timer_ext_clock_pin
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  reg [7:0]    port_a_latch;
  reg [7:0]    port_b_latch;
  reg [7:0]    port_a_direction;
  reg [7:0]    port_b_direction;
  reg [7:0]    timer_and_edge_options;
  reg [7:0]    port_b_pullup_control;
  reg [7:0]    pulldown_ctrl;
  reg [7:0]    open_drain_ctrl;
  reg [7:0]    wake_ctrl;
  reg [7:0]    power_control_reg;
  reg          global_irq_enable;
  reg [2:0]    irq_en;
  reg [2:0]    interrupt_flags;
  reg [NA-1:0] sa1;
  reg [NA-1:0] sa2;
  reg [NA-1:0] sa3;
  reg [NB-1:0] sb1;
  reg [NB-1:0] sb2;
  reg [NB-1:0] sb3;
  reg [NB-1:0] pb_stable;
  reg          stable_valid;
  reg [NA-1:0] pa_stable;
  reg          next_global_irq_enable;
  reg [7:0]    next_rdata;
  wire [2:0]   next_flags;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // A change counts only when the second and third stages agree, which
  // filters one-cycle glitches at the cost of one cycle of latency.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sa1 <= {NA{1'b0}};
      sa2 <= {NA{1'b0}};
      sa3 <= {NA{1'b0}};
      sb1 <= {NB{1'b0}};
      sb2 <= {NB{1'b0}};
      sb3 <= {NB{1'b0}};
    end
    else
    begin
      sa1 <= i_port_a_in;
      sa2 <= sa1;
      sa3 <= sa2;
      sb1 <= i_port_b_in;
      sb2 <= sb1;
      sb3 <= sb2;
    end
  end

  // Both ports filter the same way, so a port read and an edge event
  // always agree on the level that the core saw.
  wire [NA-1:0] agree_a      = ~(sa2 ^ sa3);
  wire [NA-1:0] next_a_level = (agree_a & sa2) | (~agree_a & pa_stable);
  wire [NB-1:0] agree_b      = ~(sb2 ^ sb3);
  wire [NB-1:0] next_stable  = (agree_b & sb2) | (~agree_b & pb_stable);

  // ---------------------------------------------------------------
  // Pin control
  // ---------------------------------------------------------------
  wire ext_sel = power_control_reg[`PIC_BIT_EIS];
  wire tsrc    = timer_and_edge_options[`PIC_BIT_TSRC];
  wire [NB-1:0] b_input;
  wire [NB-1:0] b_chg_en;

  genvar g;
  generate
    for (g = 0; g < NA; g = g + 1)
    begin : g_pa
      assign o_port_a_oe[g]       = ~port_a_direction[g];
      assign o_port_a_out[g]      = port_a_latch[g];
      assign o_port_a_pulldown[g] = port_a_direction[g] & ~pulldown_ctrl[g];
    end
    for (g = 0; g < NB; g = g + 1)
    begin : g_pb
      if (g == 3)
      begin : g_in_only
        assign b_input[g] = 1'b1;
      end
      // The timer clock source overrides the direction bit, so a stale
      // output setting cannot fight an external clock.
      else if (g == 2)
      begin : g_tclk
        assign b_input[g] = port_b_direction[g] | tsrc;
      end
      else
      begin : g_norm
        assign b_input[g] = port_b_direction[g];
      end
      // Open drain: drive only while latch is low.
      assign o_port_b_oe[g]  = ~b_input[g] & (~open_drain_ctrl[g] | ~port_b_latch[g] | (g == 3));
      assign o_port_b_out[g] = port_b_latch[g] & ~open_drain_ctrl[g];
      if (g == 3)
      begin : g_no_pullup
        // The input-only pin has no pull-up at all.
        assign o_port_b_pullup[g] = 1'b0;
      end
      else
      begin : g_pullup
        assign o_port_b_pullup[g] = b_input[g] & ~port_b_pullup_control[g];
      end
      // Only the three low pins of port B have a pull-down; their control
      // bits sit just above the four port A bits.
      if (g < 3)
      begin : g_pulldown
        assign o_port_b_pulldown[g] = b_input[g] & ~pulldown_ctrl[g + 4];
      end
      else
      begin : g_no_pulldown
        assign o_port_b_pulldown[g] = 1'b0;
      end
      assign b_chg_en[g] = wake_ctrl[g] & b_input[g] & ~((g == 0) & ext_sel);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------
  wire int_now  = next_stable[0];
  wire int_prev = pb_stable[0];
  wire edge_rise = timer_and_edge_options[`PIC_BIT_EDGE];
  wire int_rise  = int_now & ~int_prev;
  wire int_fall  = ~int_now & int_prev;
  wire ext_event = stable_valid & ext_sel &
                   (edge_rise ? int_rise : int_fall);
  wire pb_event  = stable_valid & |((next_stable ^ pb_stable) & b_chg_en);
  wire [2:0] events = {ext_event, pb_event, i_timer_rollover};

  // ---------------------------------------------------------------
  // Interrupt request and wake-up
  // ---------------------------------------------------------------
  // A request is held off while the core sleeps; it wakes first and
  // then branches or resumes according to the global enable.
  wire [2:0] pending = interrupt_flags & irq_en;
  assign o_irq_take    = global_irq_enable & |pending & ~i_sleeping;
  assign o_irq_vector  = `PIC_VECTOR_IRQ;
  assign o_wake        = i_sleeping & |pending;
  assign o_wake_branch = o_wake & global_irq_enable;

  // ---------------------------------------------------------------
  // Option fields
  // ---------------------------------------------------------------
  // These steer the timer and prescaler outside this block, and bit 5 also
  // holds port B pin 2 as an input; bit 7 is stored but drives nothing.
  assign o_timer_source_select = tsrc;
  assign o_timer_source_edge   = timer_and_edge_options[`PIC_BIT_TEDGE];
  assign o_prescaler_assign    = timer_and_edge_options[`PIC_BIT_PSA];
  assign o_prescaler_rate      = timer_and_edge_options[2:0];
  assign o_timer_ext_clock_pin = pb_stable[2];

  wire wr_flags = i_wr & (i_addr == `PIC_ADDR_IRQ_FLAGS);
  wire wr_en    = i_wr & (i_addr == `PIC_ADDR_IRQ_ENABLE);

  // ---------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------
  // A software write stores the written bit, but an event in the same
  // cycle sets the flag anyway, so no edge is ever lost to a clear.
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_flag
      assign next_flags[g] = (wr_flags ? i_wdata[g] : interrupt_flags[g])
                             | events[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Global enable
  // ---------------------------------------------------------------
  // Taking an interrupt wins over a return in the same cycle, so a
  // pending source cannot re-enter before its flag is cleared.
  always @*
  begin
    next_global_irq_enable = global_irq_enable;
    if (o_irq_take)
      next_global_irq_enable = 1'b0;
    else if (i_return_from_interrupt)
      next_global_irq_enable = 1'b1;
    else if (wr_en)
      next_global_irq_enable = i_wdata[`PIC_BIT_GIE];
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      port_a_latch           <= 8'h00;
      port_b_latch           <= 8'h00;
      port_a_direction       <= `PIC_DIR_RESET;
      port_b_direction       <= `PIC_DIR_RESET;
      timer_and_edge_options <= `PIC_OPTION_RESET;
      port_b_pullup_control  <= `PIC_PULLUP_RESET;
      pulldown_ctrl          <= `PIC_PULLDOWN_RESET;
      open_drain_ctrl        <= 8'h00;
      wake_ctrl              <= 8'h00;
      power_control_reg      <= 8'h00;
      global_irq_enable      <= 1'b0;
      irq_en                 <= 3'h0;
      interrupt_flags        <= 3'h0;
      pb_stable              <= {NB{1'b0}};
      pa_stable              <= {NA{1'b0}};
      stable_valid           <= 1'b0;
    end
    else
    begin
      pb_stable    <= next_stable;
      pa_stable    <= next_a_level;
      stable_valid <= 1'b1;
      if (i_option_load)
        timer_and_edge_options <= i_accumulator_reg;
      if (i_direction_load && i_direction_addr == `PIC_ADDR_PORT_A)
        port_a_direction <= i_accumulator_reg;
      if (i_direction_load && i_direction_addr == `PIC_ADDR_PORT_B)
        port_b_direction <= i_accumulator_reg;
      // Writes to unmapped addresses fall into the default branch and
      // leave every register as it was.
      if (i_wr)
      begin
        case (i_addr)
          `PIC_ADDR_PORT_A:     port_a_latch <= i_wdata;
          `PIC_ADDR_PORT_B:     port_b_latch <= i_wdata;
          `PIC_ADDR_POWER_CTRL: power_control_reg <= i_wdata;
          `PIC_ADDR_WAKE_CTRL:  wake_ctrl <= i_wdata;
          `PIC_ADDR_PULLDOWN:   pulldown_ctrl <= i_wdata;
          `PIC_ADDR_OPEN_DRAIN: open_drain_ctrl <= i_wdata;
          `PIC_ADDR_PULLUP:     port_b_pullup_control <= i_wdata;
          `PIC_ADDR_IRQ_ENABLE: irq_en <= i_wdata[2:0];
          default:              port_a_latch <= port_a_latch;
        endcase
      end
      interrupt_flags   <= next_flags;
      global_irq_enable <= next_global_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // The data is chosen combinationally and captured on the read strobe,
  // so the core sees a value that holds until its next read.
  always @*
  begin
    case (i_addr)
      `PIC_ADDR_PORT_A:     next_rdata = {port_a_latch[7:NA], pa_stable & ~i_alt_func_a};
      `PIC_ADDR_PORT_B:     next_rdata = pb_stable & ~i_alt_func_b;
      `PIC_ADDR_POWER_CTRL: next_rdata = power_control_reg | `PIC_POWER_ONES;
      `PIC_ADDR_WAKE_CTRL:  next_rdata = wake_ctrl;
      `PIC_ADDR_PULLDOWN:   next_rdata = pulldown_ctrl;
      `PIC_ADDR_OPEN_DRAIN: next_rdata = open_drain_ctrl;
      `PIC_ADDR_PULLUP:     next_rdata = port_b_pullup_control;
      `PIC_ADDR_IRQ_ENABLE: next_rdata = {global_irq_enable, 4'hF, irq_en};
      `PIC_ADDR_IRQ_FLAGS:  next_rdata = {5'h00, interrupt_flags & irq_en};
      default:              next_rdata = 8'h00;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= next_rdata;
  end

endmodule // pic_port_irq

// ===== core/pic_regs.vh
// Register offsets, field positions, reset values and timing counts for the port block.
`ifndef PIC_REGS_VH
`define PIC_REGS_VH
`define PIC_ADDR_PORT_A        8'h05
`define PIC_ADDR_PORT_B        8'h06
`define PIC_ADDR_POWER_CTRL    8'h08
`define PIC_ADDR_WAKE_CTRL     8'h09
`define PIC_ADDR_PULLDOWN      8'h0B
`define PIC_ADDR_OPEN_DRAIN    8'h0C
`define PIC_ADDR_PULLUP        8'h0D
`define PIC_ADDR_IRQ_ENABLE    8'h0E
`define PIC_ADDR_IRQ_FLAGS     8'h0F
`define PIC_BIT_GIE            7
`define PIC_BIT_EXT            2
`define PIC_BIT_PBC            1
`define PIC_BIT_TMR            0
`define PIC_BIT_EIS            6
`define PIC_BIT_EDGE           6
`define PIC_BIT_TSRC           5
`define PIC_BIT_TEDGE          4
`define PIC_BIT_PSA            3
`define PIC_ENABLE_ONES        8'h78
`define PIC_FLAG_MASK          8'h07
`define PIC_OPTION_RESET       8'hBF
`define PIC_DIR_RESET          8'hFF
`define PIC_PULLUP_RESET       8'hFF
`define PIC_PULLDOWN_RESET     8'hFF
`define PIC_POWER_ONES         8'h1F
`define PIC_VECTOR_IRQ         11'h008
`define PIC_PIN_SYNC_STAGES    3
`endif

// ===== verif/pic_port_irq_monitor.sv
// Concurrent checks on the port and interrupt block, bound to its ports.
`timescale 1ns/100ps
module pic_port_irq_monitor
#(parameter NA = 4, parameter NB = 8)
(
  input logic          i_clk,
  input logic          i_rst,
  input logic [7:0]    i_addr,
  input logic          i_rd,
  input logic [7:0]    o_rdata,
  input logic [7:0]    i_accumulator_reg,
  input logic          i_option_load,
  input logic          i_direction_load,
  input logic [7:0]    i_direction_addr,
  input logic [NB-1:0] o_port_b_oe,
  input logic [NB-1:0] o_port_b_pullup,
  input logic          o_irq_take,
  input logic [10:0]   o_irq_vector,
  input logic          o_wake,
  input logic          o_wake_branch,
  input logic          o_timer_source_select,
  input logic [2:0]    o_prescaler_rate
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Reset is the cause here, so this one check is not disabled by it.
  property p_rst;
    disable iff (1'b0) i_rst |=>
      !o_port_b_oe && o_prescaler_rate == 3'h7 && o_timer_source_select;
  endproperty
  property p_pin3; !o_port_b_oe[3]; endproperty
  property p_pull; !(o_port_b_pullup & o_port_b_oe) && !o_port_b_pullup[3]; endproperty
  property p_tsrc; o_timer_source_select |-> !o_port_b_oe[2]; endproperty
  property p_take; o_irq_take |-> o_irq_vector == 11'h008 ##1 !o_irq_take; endproperty
  property p_opt; i_option_load |=> o_prescaler_rate == $past(i_accumulator_reg[2:0]); endproperty
  property p_dir;
    i_direction_load && i_direction_addr == 8'h06 |=>
      o_port_b_oe == (~$past(i_accumulator_reg) & 8'hF7 & ~{5'h00, o_timer_source_select, 2'h0});
  endproperty
  property p_rd; i_rd && i_addr == 8'h0F |=> o_rdata[7:3] == 5'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_pin3: assert property (p_pin3) else $error("input-only pin driven");
  a_pull: assert property (p_pull) else $error("pull-up on output pin");
  a_tsrc: assert property (p_tsrc) else $error("timer pin not forced to input");
  a_take: assert property (p_take) else $error("bad vector or repeated take");
  a_opt: assert property (p_opt) else $error("option rate not loaded");
  a_dir: assert property (p_dir) else $error("direction not loaded");
  a_rd: assert property (p_rd) else $error("flag upper bits not zero");
  c_take: cover property (o_irq_take);
  c_wake: cover property (o_wake && !o_wake_branch);
  c_branch: cover property (o_wake_branch);
endmodule // pic_port_irq_monitor

bind pic_port_irq pic_port_irq_monitor #(.NA(NA), .NB(NB)) i_pic_port_irq_monitor (.*);

// ===== verif/pic_pin_model.sv
// Behavioural model of the circuits hanging on the port pins.
`timescale 1ns/100ps
module pic_pin_model
#(parameter N = 8)
(
  input  logic [N-1:0] i_out,
  input  logic [N-1:0] i_oe,
  input  logic [N-1:0] i_pullup,
  input  logic [N-1:0] i_pulldown,
  input  logic [N-1:0] i_ext,
  output logic [N-1:0] o_pin
);
  // A driven pin follows the latch; a weak pull beats the loose external source.
  always_comb
    for (int k = 0; k < N; k++)
      o_pin[k] = i_oe[k] ? i_out[k] : i_pullup[k] ? 1'b1 : i_pulldown[k] ? 1'b0 : i_ext[k];
endmodule // pic_pin_model

// ===== verif/test_port_and_interrupt_control.sv
// Self-checking bench for the port and interrupt block.
`timescale 1ns/100ps
module test_port_and_interrupt_control;
  logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_sleeping = 0, pend = 0;
  logic        i_option_load = 0, i_direction_load = 0, i_timer_rollover = 0;
  logic        i_return_from_interrupt = 0, o_irq_take, o_wake, o_wake_branch;
  logic        o_timer_source_select, o_timer_source_edge, o_prescaler_assign;
  logic        o_timer_ext_clock_pin;
  logic [2:0]  o_prescaler_rate;
  logic [3:0]  i_port_a_in, o_port_a_out, o_port_a_oe, o_port_a_pulldown;
  logic [7:0]  i_addr = 0, i_wdata = 0, i_accumulator_reg = 0, i_direction_addr = 0;
  logic [7:0]  o_rdata, i_port_b_in, o_port_b_out, o_port_b_oe, o_port_b_pullup;
  logic [7:0]  o_port_b_pulldown, ext_b = 0, i_alt_func_b = 0, r, p;
  logic [3:0]  i_alt_func_a = 0;
  logic [10:0] o_irq_vector;
  logic [7:0]  exp_q[$];
  int          n_errors = 0, compares = 0, cyc = 0;
  wire  [7:0]  opt_v = {2'h0, o_timer_source_select, o_timer_source_edge,
                        o_prescaler_assign, o_prescaler_rate};

  always #10 i_clk = ~i_clk;
  pic_port_irq i_pic_port_irq (.*);
  pic_pin_model #(.N(4)) i_pic_pin_model_a (.i_out(o_port_a_out), .i_oe(o_port_a_oe),
    .i_pullup(4'h0), .i_pulldown(o_port_a_pulldown), .i_ext(4'h5), .o_pin(i_port_a_in));
  pic_pin_model #(.N(8)) i_pic_pin_model_b (.i_out(o_port_b_out), .i_oe(o_port_b_oe),
    .i_pullup(o_port_b_pullup), .i_pulldown(o_port_b_pulldown), .i_ext(ext_b),
    .o_pin(i_port_b_in));

  task chk(input logic [7:0] e, input logic [7:0] s, input string nm);
    compares++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  // A read notes its expected data; the watcher below compares it a cycle later.
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    {i_wr, i_rd} = {w, ~w};
    if (!w)
      exp_q.push_back(d);
    @(negedge i_clk);
    {i_wr, i_rd} = 2'b00;
  endtask
  task strobe(input logic [3:0] m, input logic [7:0] acc, input logic [7:0] da);
    @(negedge i_clk);
    i_accumulator_reg = acc;
    i_direction_addr = da;
    {i_option_load, i_direction_load, i_timer_rollover, i_return_from_interrupt} = m;
    @(negedge i_clk);
    {i_option_load, i_direction_load, i_timer_rollover, i_return_from_interrupt} = 4'h0;
  endtask
  task wrap_up;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge i_clk) pend <= i_rd;
  always @(negedge i_clk) if (pend) chk(exp_q.pop_front(), o_rdata, "rdata");
  // The run needs well under a thousand cycles; a hang is cut off far beyond that.
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    r = $urandom(56936);
    repeat (4) @(negedge i_clk);
    i_rst = 0;
    chk(8'h00, {o_port_a_oe, o_port_b_oe[3:0] | o_port_b_oe[7:4]}, "oe");
    chk(8'h3F, opt_v, "option");
    bus(0, 8'h0E, 8'h78);
    bus(0, 8'h0F, 8'h00);
    bus(0, 8'h1F, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      strobe(4'h8, {r[7:6], k[2:0], ~k[2:0]}, 8'h00);
      chk({2'h0, k[2:0], ~k[2:0]}, opt_v, "option");
    end
    $display("reset and option tests done");
    strobe(4'h8, 8'h00, 8'h00);
    r = $urandom;
    p = $urandom;
    strobe(4'h4, r, 8'h06);
    chk(~r & 8'hF7, o_port_b_oe, "oe_b");
    strobe(4'h4, ~r, 8'h05);
    chk({4'h0, r[3:0]}, {4'h0, o_port_a_oe}, "oe_a");
    bus(1, 8'h06, p);
    chk(p & ~r & 8'hF7, o_port_b_out & o_port_b_oe, "out_b");
    strobe(4'h8, 8'h20, 8'h00);
    bus(1, 8'h0D, p);
    chk(~r & 8'hF3, o_port_b_oe, "oe_b");
    chk(~p & (r | 8'h0C) & 8'hF7, o_port_b_pullup, "pullup");
    bus(0, 8'h0D, p);
    $display("direction and pull tests done");
    strobe(4'h8, 8'h00, 8'h00);
    strobe(4'h4, 8'hFF, 8'h06);
    bus(1, 8'h0E, 8'h00);
    strobe(4'h2, 8'h00, 8'h00);
    bus(0, 8'h0F, 8'h00);
    bus(1, 8'h0E, 8'h01);
    bus(0, 8'h0F, 8'h01);
    bus(1, 8'h0E, 8'h81);
    bus(0, 8'h0E, 8'h79);
    bus(1, 8'h0F, 8'h00);
    strobe(4'h1, 8'h00, 8'h00);
    bus(0, 8'h0E, 8'hF9);
    i_sleeping = 1;
    bus(1, 8'h0E, 8'h01);
    strobe(4'h2, 8'h00, 8'h00);
    chk(8'h02, {6'h00, o_wake, o_wake_branch}, "wake");
    bus(1, 8'h0E, 8'h81);
    chk(8'h03, {6'h00, o_wake, o_wake_branch}, "wake");
    i_sleeping = 0;
    bus(0, 8'h0E, 8'h79);
    $display("interrupt tests done");
    bus(1, 8'h0D, 8'hFF);
    bus(1, 8'h08, 8'h40);
    bus(1, 8'h09, 8'h81);
    bus(1, 8'h0E, 8'h06);
    for (int e = 0; e < 2; e++)
    begin
      strobe(4'h8, {1'b0, e[0], 6'h00}, 8'h00);
      ext_b[0] = ~e[0];
      repeat (6) @(negedge i_clk);
      bus(1, 8'h0F, 8'h00);
      ext_b[0] = e[0];
      repeat (6) @(negedge i_clk);
      bus(0, 8'h0F, 8'h04);
      bus(1, 8'h0F, 8'h00);
      ext_b[0] = ~e[0];
      repeat (6) @(negedge i_clk);
      bus(0, 8'h0F, 8'h00);
    end
    ext_b[7] = 1'b1;
    repeat (6) @(negedge i_clk);
    bus(0, 8'h0F, 8'h02);
    bus(0, 8'h0F, 8'h02);
    i_alt_func_b = $urandom;
    bus(0, 8'h06, ext_b & ~i_alt_func_b);
    $display("pin tests done");
    ext_b[2] = 1'b1;
    i_alt_func_a = $urandom;
    repeat (6) @(negedge i_clk);
    chk(8'h01, {7'h00, o_timer_ext_clock_pin}, "tclk");
    bus(0, 8'h05, {4'h0, 4'h5 & ~r[3:0] & ~i_alt_func_a});
    bus(1, 8'h0B, 8'h00);
    chk({~r[3:0], 4'h7}, {o_port_a_pulldown, 1'b0, o_port_b_pulldown[2:0]}, "pulldown");
    strobe(4'h4, 8'h00, 8'h06);
    bus(1, 8'h0C, 8'hF7);
    bus(1, 8'h06, 8'h5A);
    chk(8'hA5, o_port_b_oe, "oe_od");
    chk(8'h00, o_port_b_out & o_port_b_oe, "out_od");
    chk(8'h00, o_port_b_pullup | o_port_b_pulldown, "pull_out");
    $display("pulldown and open-drain tests done");
    repeat (3) @(negedge i_clk);
    wrap_up();
  end
endmodule // test_port_and_interrupt_control
